/* File: rtl/vdc_converter_ctrl.sv */
// Top of the converter control block: APB registers, mode logic, DMA pacing.
//
// Overview of operation
// [RULE_01] With the interpolation bit clear the converter takes the 12-bit main code field.
// [RULE_02] With the interpolation bit set it takes 16 bits, updated at the slower tick rate.
// [RULE_03] Loop-driver mode forces interpolation off; software must not combine them.
// [RULE_04] The output buffer is on by default and the bypass bit routes around it.
// [RULE_05] Software ungates the system clock to this block elsewhere before using it.
// [RULE_06] Sample transfers are served by DMA channel eight through the request line.
// [RULE_07] In waveform mode each DMA write is paced by the timer 1 event.
// [RULE_08] The DMA bit selects whether samples are requested from the DMA channel.
// [RULE_09] Control sits at offset 0x0 resetting to 0x200, samples at 0x4 resetting to zero.
// [RULE_10] The range field picks the 1.2 V reference span or the 1.8 V supply span.
// [RULE_11] The rate bit picks an interpolation tick of clock/32 or clock/16.
// [RULE_12] The update-source bit picks the system clock or the timer 1 falling edge.
// [RULE_13] Writing zero to the clear bit zeroes the output and the sample register at once.
// [RULE_14] The sample word carries the main code in 27:16 and extra bits in 15:12.
// [RULE_15] The applied code is captured at an update event and held until the next one.
`timescale 1ns/1ps
`default_nettype none
module vdc_converter_ctrl
  import vdc_pkg::*;
#(
  parameter int CHANNEL = VDC_DMA_CHANNEL
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // DMA channel
  output logic dmaReq,
  input wire logic dmaAck,
  input wire logic [31:0] dmaData,
  // Timer 1 strobe
  input wire logic timerEvent,
  // Analog core controls
  output logic [VDC_CODE_W-1:0] convCode,
  output logic interpActive,
  output logic [1:0] outputRangeSelect,
  output logic outputBufferBypass,
  output logic loopDriverMode,
  output logic powerDown,
  output logic updateStrobe
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  function automatic logic [VDC_CODE_W-1:0] pickCode(
    input logic [31:0] word, input logic wide);
    logic [VDC_MAIN_W-1:0] mainField;
    logic [VDC_EXTRA_W-1:0] extraField;
    mainField = word[VDC_MAIN_LSB +: VDC_MAIN_W];
    extraField = word[VDC_EXTRA_LSB +: VDC_EXTRA_W];
    pickCode = wide ? {mainField, extraField}
                    : {mainField, {VDC_EXTRA_W{1'b0}}};
  endfunction : pickCode

  // ----------------------------------------------------------------------
  // Registers and decode
  // ----------------------------------------------------------------------
  logic [15:0] converterControl;
  logic [31:0] converterSample;
  logic accessWr;
  logic hitCtrl;
  logic hitSample;
  logic ctrlWrite;
  logic sampleWrite;
  logic clearNow;
  logic interpSel;
  logic timerFall;
  logic divTick;
  logic updateEvent;
  vdc_dma_state_t dmaState;
  vdc_dma_state_t next_dmaState;

  assign hitCtrl = hit(paddr, VDC_OFS_CONTROL);
  assign hitSample = hit(paddr, VDC_OFS_SAMPLE);
  assign accessWr = psel && penable && pwrite;
  assign pready = 1'b1;
  // Unmapped addresses and bus writes to the read-only sample register error.
  assign pslverr = psel && penable &&
                   (!(hitCtrl || hitSample) || (pwrite && hitSample));
  assign ctrlWrite = accessWr && hitCtrl;
  // A write of zero to the clear bit acts in the same cycle. [RULE_13]
  assign clearNow = ctrlWrite && !pwdata[VDC_CLEAR_N_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      converterControl <= VDC_CONTROL_RESET; // [RULE_09]
    end else if (ctrlWrite) begin
      converterControl <= pwdata[15:0] & VDC_CONTROL_WMASK;
    end
  end

  // ----------------------------------------------------------------------
  // Sample register, fed by the DMA channel
  // ----------------------------------------------------------------------
  // The bus sees this register read-only; only the DMA channel writes it.
  assign sampleWrite = dmaAck && (dmaState == VDC_REQ);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      converterSample <= VDC_SAMPLE_RESET; // [RULE_09]
    end else if (clearNow || !converterControl[VDC_CLEAR_N_BIT]) begin
      converterSample <= VDC_SAMPLE_RESET; // [RULE_13]
    end else if (sampleWrite) begin
      converterSample <= dmaData & VDC_SAMPLE_MASK; // [RULE_14]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (hitCtrl) begin
        prdata <= {16'h0000, converterControl};
      end else if (hitSample) begin
        prdata <= converterSample;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  assign loopDriverMode = converterControl[VDC_LOOP_BIT];
  // Loop-driver mode cannot interpolate, so it wins over the mode bit.
  assign interpSel = converterControl[VDC_INTERP_BIT] && !loopDriverMode; // [RULE_03]
  assign interpActive = interpSel; // [RULE_01] [RULE_02]
  assign outputBufferBypass = converterControl[VDC_BYPASS_BIT]; // [RULE_04]
  assign outputRangeSelect =
    converterControl[VDC_RANGE_LSB +: 2]; // [RULE_10]
  assign powerDown = converterControl[VDC_POWERDOWN_BIT];

  // ----------------------------------------------------------------------
  // Update events
  // ----------------------------------------------------------------------
  vdc_edge_detect u_timer_edge (
    .clk(clk),
    .nrst(nrst),
    .level(timerEvent),
    .fallPulse(timerFall)
  );

  vdc_interp_div u_div (
    .clk(clk),
    .nrst(nrst),
    .enable(interpSel),
    .fastSel(converterControl[VDC_RATE_BIT]), // [RULE_11]
    .tick(divTick)
  );

  // The system-clock choice updates every cycle, which stands for the
  // falling edge here; interpolation further slows it to the divider tick.
  always_comb begin
    if (converterControl[VDC_UPDSRC_BIT]) begin
      updateEvent = timerFall; // [RULE_12]
    end else begin
      updateEvent = 1'b1; // [RULE_12]
    end
    if (interpSel) begin
      updateEvent = updateEvent && divTick; // [RULE_02]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      convCode <= '0;
    end else if (clearNow || !converterControl[VDC_CLEAR_N_BIT]) begin
      convCode <= '0; // [RULE_13]
    end else if (updateEvent) begin
      convCode <= pickCode(converterSample, interpSel); // [RULE_15] [RULE_01]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      updateStrobe <= 1'b0;
    end else begin
      updateStrobe <= updateEvent && !clearNow;
    end
  end

  // ----------------------------------------------------------------------
  // DMA pacing
  // ----------------------------------------------------------------------
  // One request per timer event; an event during a pending request is
  // dropped, trading a missed sample for a bounded request line.
  always_comb begin
    next_dmaState = dmaState;
    case (dmaState)
      VDC_IDLE: begin
        if (converterControl[VDC_DMA_BIT]) begin
          next_dmaState = VDC_WAIT; // [RULE_08]
        end
      end
      VDC_WAIT: begin
        if (!converterControl[VDC_DMA_BIT]) begin
          next_dmaState = VDC_IDLE;
        end else if (timerFall) begin
          next_dmaState = VDC_REQ; // [RULE_07]
        end
      end
      VDC_REQ: begin
        if (!converterControl[VDC_DMA_BIT]) begin
          next_dmaState = VDC_IDLE;
        end else if (dmaAck) begin
          next_dmaState = VDC_WAIT;
        end
      end
      default: begin
        next_dmaState = VDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dmaState <= VDC_IDLE;
    end else begin
      dmaState <= next_dmaState;
    end
  end

  // This line is wired to the converter's own DMA channel. [RULE_06]
  assign dmaReq = (dmaState == VDC_REQ);
endmodule : vdc_converter_ctrl
`default_nettype wire

/* File: rtl/vdc_pkg.sv */
// Package with register map, field positions and timing counts of the converter control block.
package vdc_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] VDC_OFS_CONTROL = 12'h000;
  localparam logic [11:0] VDC_OFS_SAMPLE = 12'h004;
  localparam logic [15:0] VDC_CONTROL_RESET = 16'h0200;
  localparam logic [31:0] VDC_SAMPLE_RESET = 32'h00000000;
  localparam logic [15:0] VDC_CONTROL_WMASK = 16'h077f;
  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int VDC_RANGE_LSB = 0;
  localparam int VDC_RATE_BIT = 2;
  localparam int VDC_INTERP_BIT = 3;
  localparam int VDC_CLEAR_N_BIT = 4;
  localparam int VDC_UPDSRC_BIT = 5;
  localparam int VDC_BYPASS_BIT = 6;
  localparam int VDC_LOOP_BIT = 8;
  localparam int VDC_POWERDOWN_BIT = 9;
  localparam int VDC_DMA_BIT = 10;
  localparam logic [1:0] VDC_RANGE_REF = 2'h0;
  localparam logic [1:0] VDC_RANGE_SUPPLY = 2'h3;
  // ----------------------------------------------------------------------
  // Sample register fields
  // ----------------------------------------------------------------------
  localparam int VDC_MAIN_LSB = 16;
  localparam int VDC_MAIN_W = 12;
  localparam int VDC_EXTRA_LSB = 12;
  localparam int VDC_EXTRA_W = 4;
  localparam int VDC_CODE_W = VDC_MAIN_W + VDC_EXTRA_W;
  localparam logic [31:0] VDC_SAMPLE_MASK = 32'h0ffff000;
  // ----------------------------------------------------------------------
  // Interpolation clock dividers and DMA channel number
  // ----------------------------------------------------------------------
  localparam int VDC_DIV_SLOW = 32;
  localparam int VDC_DIV_FAST = 16;
  localparam int VDC_DMA_CHANNEL = 8;
  // ----------------------------------------------------------------------
  // DMA pacing state machine
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    VDC_IDLE = 3'b001,
    VDC_WAIT = 3'b010,
    VDC_REQ = 3'b100
  } vdc_dma_state_t;
endpackage : vdc_pkg

/* File: rtl/vdc_edge_detect.sv */
// Falling-edge detector for an update strobe that is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module vdc_edge_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Strobe in, pulse out
  input wire logic level,
  output logic fallPulse
);
  logic levelDly;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      levelDly <= 1'b0;
    end else begin
      levelDly <= level;
    end
  end

  // A registered copy keeps the pulse exactly one cycle wide.
  assign fallPulse = levelDly & ~level;
endmodule : vdc_edge_detect
`default_nettype wire

/* File: rtl/vdc_interp_div.sv */
// Interpolation tick divider, selectable between two ratios.
`timescale 1ns/1ps
`default_nettype none
module vdc_interp_div
  import vdc_pkg::*;
#(
  parameter int DIV_SLOW = VDC_DIV_SLOW,
  parameter int DIV_FAST = VDC_DIV_FAST
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic enable,
  input wire logic fastSel,
  // Tick out
  output logic tick
);
  localparam int CW = $clog2(DIV_SLOW);
  localparam logic [CW-1:0] LAST_SLOW = CW'(DIV_SLOW - 1);
  localparam logic [CW-1:0] LAST_FAST = CW'(DIV_FAST - 1);
  logic [CW-1:0] count;
  logic [CW-1:0] last;

  assign last = fastSel ? LAST_FAST : LAST_SLOW;
  assign tick = enable && (count >= last);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (!enable || count >= last) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : vdc_interp_div
`default_nettype wire

/* File: testbench/vdc_converter_ctrl_props.sv */
// Checker of register, DMA and mode behaviour at the converter ports.
`timescale 1ns/1ps
`default_nettype none
module vdc_converter_ctrl_props (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // DMA and timer
  input wire logic dmaReq,
  input wire logic dmaAck,
  input wire logic [31:0] dmaData,
  input wire logic timerEvent,
  // Analog controls
  input wire logic [15:0] convCode,
  input wire logic interpActive,
  input wire logic [1:0] outputRangeSelect,
  input wire logic outputBufferBypass,
  input wire logic loopDriverMode,
  input wire logic powerDown,
  input wire logic updateStrobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic ctlWr;
  logic access;
  assign access = psel && penable;
  assign ctlWr = access && pwrite && paddr == 12'h000;
  loop_no_interp_a: assert property (
    loopDriverMode |-> !interpActive) else $error("interp in loop mode");
  sample_ro_a: assert property (
    access && pwrite && paddr == 12'h004 |-> pslverr)
    else $error("sample write accepted");
  unmapped_err_a: assert property (
    access && paddr > 12'h004 |-> pslverr) else $error("unmapped ok");
  bypass_follow_a: assert property (
    ctlWr |=> outputBufferBypass == $past(pwdata[6]))
    else $error("bypass wrong");
  range_follow_a: assert property (
    ctlWr |=> outputRangeSelect == $past(pwdata[1:0]))
    else $error("range wrong");
  ack_drops_a: assert property (
    dmaReq && dmaAck |=> !dmaReq) else $error("request held");
  clear_zero_a: assert property (
    ctlWr && !pwdata[4] |=> convCode == 16'h0000)
    else $error("clear ignored");
  reserved_zero_a: assert property (
    access && !pwrite && paddr == 12'h000 |-> prdata[31:11] == 21'h0
    && !prdata[7]) else $error("reserved bits set");
endmodule : vdc_converter_ctrl_props
`default_nettype wire

/* File: testbench/vdc_dma_partner.sv */
// Behavioural DMA channel and timer 1 pacing model.
`timescale 1ns/1ps
`default_nettype none
module vdc_dma_partner #(
  parameter int PERIOD = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bench controls
  input wire logic run,
  input wire logic [3:0] lag,
  // DMA channel
  input wire logic dmaReq,
  output logic dmaAck,
  output logic [31:0] dmaData,
  output logic [7:0] sent,
  // Timer strobe
  output logic timerEvent
);
  logic [7:0] tc;
  logic [3:0] waitCnt;
  logic [31:0] word;
  // Reserved bits carry junk so that the masking is exercised.
  assign word = {4'ha, 12'h100 + {4'h0, sent}, sent[3:0], 12'h5a5};
  // Outside an ack the bus shows the inverse, never a stale word.
  assign dmaData = dmaAck ? word : ~word;
  // The timer strobe stays low while stopped; the count keeps running.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tc <= 8'h00;
      timerEvent <= 1'b0;
    end else begin
      tc <= (tc == PERIOD - 1) ? 8'h00 : tc + 8'h01;
      timerEvent <= run && (tc < PERIOD / 2);
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dmaAck <= 1'b0;
      waitCnt <= 4'h0;
      sent <= 8'h00;
    end else begin
      dmaAck <= 1'b0;
      if (dmaAck) sent <= sent + 8'h01;
      if (dmaReq && !dmaAck) begin
        dmaAck <= (waitCnt == lag);
        waitCnt <= (waitCnt == lag) ? 4'h0 : waitCnt + 4'h1;
      end
    end
  end
endmodule : vdc_dma_partner
`default_nettype wire

/* File: testbench/vdc_converter_ctrl_tb.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`default_nettype none
module vdc_converter_ctrl_tb;
  import vdc_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, dmaData;
  logic pready, pslverr, dmaReq, dmaAck, timerEvent, err;
  logic interpActive, outputBufferBypass, loopDriverMode, powerDown;
  logic updateStrobe;
  logic [15:0] convCode;
  logic [1:0] outputRangeSelect;
  logic [3:0] lag = 4'h0;
  logic [7:0] sent;
  int nErrors = 0, nCompared = 0, g;
  always #5 clk = ~clk;
  vdc_converter_ctrl u_vdc_converter_ctrl (.clk(clk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dmaReq(dmaReq), .dmaAck(dmaAck), .dmaData(dmaData),
    .timerEvent(timerEvent), .convCode(convCode),
    .interpActive(interpActive), .outputRangeSelect(outputRangeSelect),
    .outputBufferBypass(outputBufferBypass),
    .loopDriverMode(loopDriverMode), .powerDown(powerDown),
    .updateStrobe(updateStrobe));
  vdc_dma_partner u_vdc_dma_partner (.clk(clk), .nrst(nrst), .run(run),
    .lag(lag), .dmaReq(dmaReq), .dmaAck(dmaAck), .dmaData(dmaData),
    .sent(sent), .timerEvent(timerEvent));
  task automatic finalReport;
    if (nErrors == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finalReport
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      nErrors++;
      finalReport();
    end
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask : rdchk
  // Waits are bounded so that a dead request line cannot hang the run.
  task automatic untilSent(input logic [7:0] n);
    int k;
    k = 0;
    while (sent < n && k < 500) begin
      @(posedge clk);
      k++;
    end
    if (k >= 500) begin
      nErrors++;
      finalReport();
    end
  endtask : untilSent
  // A strobe still standing from the old mode must not start the count.
  task automatic gap(output int n);
    int k;
    k = 0;
    while (updateStrobe !== 1'b0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    while (updateStrobe !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
    @(posedge clk);
    n = 1;
    while (updateStrobe !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (k >= 200 || n >= 100) begin
      nErrors++;
      finalReport();
    end
  endtask : gap
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rdchk(12'h000, {16'h0, VDC_CONTROL_RESET}, "control");
    rdchk(12'h004, VDC_SAMPLE_RESET, "sample");
    chk("power and code", {powerDown, convCode}, 17'h10000);
    apb(1'b1, 12'h000, 32'hffffffff);
    rdchk(12'h000, 32'h077f, "control mask");
    chk("bypass", outputBufferBypass, 1'b1);
    chk("loop mode", {loopDriverMode, interpActive}, 2'b10);
    chk("range", outputRangeSelect, 2'h3);
    apb(1'b1, 12'h004, 32'h0fff0000);
    chk("ro write", err, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped", err, 1'b1);
    // Prompt answers first, then a slow channel.
    apb(1'b1, 12'h000, 32'h430);
    run <= 1'b1;
    untilSent(8'd3);
    lag <= 4'h3;
    untilSent(8'd5);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    rdchk(12'h004, 32'h01044000, "dma sample");
    apb(1'b1, 12'h000, 32'h010);
    run <= 1'b1;
    repeat (60) @(posedge clk);
    chk("no dma", {dmaReq, sent}, 9'h005);
    run <= 1'b0;
    chk("normal code", convCode, 16'h1040);
    apb(1'b1, 12'h000, 32'h018);
    gap(g);
    chk("slow tick", g, 32);
    chk("interp code", convCode, 16'h1044);
    apb(1'b1, 12'h000, 32'h01c);
    gap(g);
    chk("fast tick", g, 16);
    apb(1'b1, 12'h000, 32'h118);
    chk("loop interp", interpActive, 1'b0);
    apb(1'b1, 12'h000, 32'h400);
    chk("clear code", convCode, 16'h0);
    rdchk(12'h004, 32'h0, "clear sample");
    finalReport();
  end
endmodule : vdc_converter_ctrl_tb
bind vdc_converter_ctrl vdc_converter_ctrl_props u_props (.clk(clk),
  .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dmaReq(dmaReq), .dmaAck(dmaAck), .dmaData(dmaData),
  .timerEvent(timerEvent), .convCode(convCode), .interpActive(interpActive),
  .outputRangeSelect(outputRangeSelect), .powerDown(powerDown),
  .outputBufferBypass(outputBufferBypass), .updateStrobe(updateStrobe),
  .loopDriverMode(loopDriverMode));
`default_nettype wire
